// [verilog/pcf_regs.sv]
// Configuration register bank with forwarder of indirect oscillator packets
// Assumes the host serial port is decoded elsewhere into one-cycle requests on i_sys_clk
`include "pcf_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module pcf_regs #(
  parameter logic [23:0] IDENTITY_CODE = 24'h5a3c01 // Arbitrary value
) (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire pcf_pkg::pcf_reg_req_t i_req,
  input wire logic i_open_mode,
  input wire logic i_frac_mode,
  input wire logic i_reference_buffer_on,
  input wire logic i_cal_wr,
  input wire logic [8:0] i_cal_payload,
  output logic [23:0] o_rdata,
  output logic o_rvalid,
  output logic [4:0] o_read_pointer,
  output logic o_soft_reset,
  output logic [13:0] o_ref_divider,
  output logic [18:0] o_integer_divide,
  output logic [23:0] o_frac_divide,
  output logic o_link_busy,
  output pcf_pkg::pcf_link_t o_link
);
  import pcf_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Register storage

  logic [9:0] rstctl_reg;
  logic [13:0] refdiv_reg;
  logic [18:0] intdiv_reg;
  logic [23:0] fracdiv_reg;
  pcf_packet_t vcopkt_reg;
  logic [1:0] calsel_reg;
  logic pending_reg;
  pcf_state_t state_reg;
  logic [15:0] shift_reg;
  logic [3:0] bit_reg;
  logic [7:0] half_reg;
  logic [7:0] half_next;
  logic wr_ident;
  logic wr_pkt;

  assign wr_ident = i_req.wr && (i_req.addr == `PCF_OFF_IDENT);
  assign wr_pkt = i_req.wr && (i_req.addr == `PCF_OFF_VCOPKT);

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rstctl_reg <= `PCF_RST_RSTCTL;
      refdiv_reg <= `PCF_RST_REFDIV;
      intdiv_reg <= `PCF_RST_INTDIV;
      fracdiv_reg <= `PCF_RST_FRACDIV;
      calsel_reg <= `PCF_RST_CALSEL;
    end else if (i_req.wr) begin
      unique case (i_req.addr)
        `PCF_OFF_RSTCTL: rstctl_reg <= i_req.wdata[9:0];
        `PCF_OFF_REFDIV: refdiv_reg <= i_req.wdata[13:0];
        `PCF_OFF_INTDIV: intdiv_reg <= i_req.wdata[18:0];
        `PCF_OFF_FRACDIV: fracdiv_reg <= i_req.wdata;
        `PCF_OFF_CALCLK: calsel_reg <= i_req.wdata[`PCF_CALSEL_MSB:`PCF_CALSEL_LSB];
        default: ;
      endcase
    end
  end

  // Host write wins over a calibration update in the same cycle
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      vcopkt_reg <= `PCF_RST_VCOPKT;
    end else if (wr_pkt) begin
      vcopkt_reg <= i_req.wdata[15:0];
    end else if (i_cal_wr) begin
      vcopkt_reg.subsystem_payload <= i_cal_payload;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register zero: read pointer and soft reset

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_read_pointer <= 5'h00;
      o_soft_reset <= 1'b0;
    end else begin
      o_soft_reset <= wr_ident && i_req.wdata[`PCF_SOFT_RST_BIT];
      if (wr_ident && i_req.wdata[`PCF_SOFT_RST_BIT]) begin
        o_read_pointer <= 5'h00;
      end else if (wr_ident && i_open_mode) begin
        o_read_pointer <= i_req.wdata[`PCF_PTR_MSB:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read port, one cycle latency, unmapped reads as zero

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= 24'h000000;
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= i_req.rd;
      if (i_req.rd) begin
        unique case (i_req.addr)
          `PCF_OFF_IDENT: o_rdata <= IDENTITY_CODE;
          `PCF_OFF_RSTCTL: o_rdata <= {14'h0000, rstctl_reg};
          `PCF_OFF_REFDIV: o_rdata <= {10'h000, refdiv_reg};
          `PCF_OFF_INTDIV: o_rdata <= {5'h00, intdiv_reg};
          `PCF_OFF_FRACDIV: o_rdata <= fracdiv_reg;
          `PCF_OFF_VCOPKT: o_rdata <= {8'h00, vcopkt_reg};
          `PCF_OFF_CALCLK: o_rdata <= {9'h000, calsel_reg, 13'h0000};
          default: o_rdata <= 24'h000000;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Divider outputs; range limits are the host's burden, not checked here

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_ref_divider <= `PCF_RST_REFDIV;
      o_integer_divide <= `PCF_RST_INTDIV;
      o_frac_divide <= `PCF_RST_FRACDIV;
    end else begin
      o_ref_divider <= i_reference_buffer_on ? refdiv_reg : `PCF_RST_REFDIV;
      o_integer_divide <= intdiv_reg;
      o_frac_divide <= i_frac_mode ? fracdiv_reg : 24'h000000;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Packet forwarder
  // Calibration clock half period is 2^sel system cycles, so default sel 1
  // gives divide by 4 and never exceeds 20 MHz here

  assign half_next = 8'(1) << calsel_reg;

  // A packet written while busy waits; only the latest one is kept
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pending_reg <= 1'b0;
    end else if (wr_pkt || i_cal_wr) begin
      pending_reg <= 1'b1;
    end else if (state_reg == PCF_IDLE) begin
      pending_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg <= PCF_IDLE;
      shift_reg <= 16'h0000;
      bit_reg <= 4'h0;
      half_reg <= 8'h00;
      o_link <= '0;
      o_link_busy <= 1'b0;
    end else begin
      unique case (state_reg)
        PCF_IDLE: begin
          if (pending_reg) begin
            state_reg <= PCF_SHIFT;
            shift_reg <= vcopkt_reg;
            o_link.sdata <= vcopkt_reg[15];
            o_link.sen <= 1'b1;
            o_link_busy <= 1'b1;
            bit_reg <= 4'h0;
            half_reg <= half_next - 8'h01;
          end
        end
        PCF_SHIFT: begin
          if (half_reg != 8'h00) begin
            half_reg <= half_reg - 8'h01;
          end else begin
            half_reg <= half_next - 8'h01;
            if (!o_link.sclk) begin
              o_link.sclk <= 1'b1;
            end else begin
              o_link.sclk <= 1'b0;
              if (bit_reg == 4'hf) begin
                state_reg <= PCF_IDLE;
                o_link.sen <= 1'b0;
                o_link.sdata <= 1'b0;
                o_link_busy <= 1'b0;
              end else begin
                bit_reg <= bit_reg + 4'h1;
                shift_reg <= {shift_reg[14:0], 1'b0};
                o_link.sdata <= shift_reg[14];
              end
            end
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [4:0] rise_cnt;
  logic [7:0] high_cnt;

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rise_cnt <= 5'h00;
      high_cnt <= 8'h00;
    end else begin
      if (!o_link.sen) begin
        rise_cnt <= 5'h00;
      end else if (o_link.sclk && half_reg == 8'h00 && state_reg == PCF_SHIFT) begin
        rise_cnt <= rise_cnt;
      end else if (!o_link.sclk && half_reg == 8'h00 && state_reg == PCF_SHIFT) begin
        rise_cnt <= rise_cnt + 5'h01;
      end
      high_cnt <= o_link.sclk ? high_cnt + 8'h01 : 8'h00;
    end
  end

  ident_read_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    i_req.rd && i_req.addr == `PCF_OFF_IDENT |=> o_rvalid && o_rdata == IDENTITY_CODE)
    else $error("identity readback wrong");

  ptr_load_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    wr_ident && i_open_mode && !i_req.wdata[5] |=> o_read_pointer == $past(i_req.wdata[4:0]))
    else $error("read pointer not loaded");

  ptr_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    wr_ident && !i_open_mode && !i_req.wdata[5] |=> $stable(o_read_pointer))
    else $error("read pointer changed outside open variant");

  soft_reset_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    wr_ident && i_req.wdata[5] |=> o_soft_reset && o_read_pointer == 5'h00 ##1 !o_soft_reset)
    else $error("soft reset not a single pulse");

  ref_div_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    !i_reference_buffer_on |=> o_ref_divider == 14'h0001)
    else $error("reference divider applied without buffer");

  frac_gate_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    !i_frac_mode |=> o_frac_divide == 24'h000000)
    else $error("fractional word applied in integer mode");

  cal_keep_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    i_cal_wr && !wr_pkt |=> vcopkt_reg[6:0] == $past(vcopkt_reg[6:0])
      && vcopkt_reg[15:7] == $past(i_cal_payload))
    else $error("calibration touched select or index");

  pkt_start_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    wr_pkt && state_reg == PCF_IDLE && !pending_reg
      |=> ##1 o_link.sen && shift_reg == $past(i_req.wdata[15:0], 2) && o_link.sdata == shift_reg[15])
    else $error("packet not launched MSB first");

  frame_len_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    $fell(o_link.sen) |-> $past(rise_cnt) == 5'd16)
    else $error("frame did not carry sixteen clocks");

  half_rate_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
    $fell(o_link.sclk) |-> high_cnt == (8'(1) << calsel_reg))
    else $error("link clock high time wrong");

endmodule

`default_nettype wire

// [verilog/pcf_defs.svh]
// Offsets, field positions, reset values and timing counts of the synthesizer register bank
// Included by the package and the register bank; definitions only
`ifndef PCF_DEFS_SVH
`define PCF_DEFS_SVH

`define PCF_OFF_IDENT 5'h00
`define PCF_OFF_RSTCTL 5'h01
`define PCF_OFF_REFDIV 5'h02
`define PCF_OFF_INTDIV 5'h03
`define PCF_OFF_FRACDIV 5'h04
`define PCF_OFF_VCOPKT 5'h05
`define PCF_OFF_CALCLK 5'h0a

`define PCF_RST_RSTCTL 10'h002
`define PCF_RST_REFDIV 14'h0001
`define PCF_RST_INTDIV 19'h00019
`define PCF_RST_FRACDIV 24'h000000
`define PCF_RST_VCOPKT 16'h0000
`define PCF_RST_CALSEL 2'h1

`define PCF_PTR_MSB 4
`define PCF_SOFT_RST_BIT 5
`define PCF_CALSEL_LSB 13
`define PCF_CALSEL_MSB 14
`define PCF_PKT_BITS 16
`define PCF_CAL_CLK_MAX_MHZ 50
`define PCF_SYS_CLK_MHZ 40

`endif

// [verilog/pcf_pkg.sv]
// Types shared by the synthesizer register bank
// Assumes pcf_defs.svh is on the include path
`include "pcf_defs.svh"

package pcf_pkg;

  typedef struct packed {
    logic [8:0] subsystem_payload;
    logic [3:0] subsystem_reg_index;
    logic [2:0] subsystem_select;
  } pcf_packet_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [23:0] wdata;
  } pcf_reg_req_t;

  typedef struct packed {
    logic sclk;
    logic sdata;
    logic sen;
  } pcf_link_t;

  typedef enum logic [0:0] {
    PCF_IDLE,
    PCF_SHIFT
  } pcf_state_t;

endpackage

// [bench/pcf_vco_model.sv]
// Receiving end of the internal oscillator link
// Assumes frames from pcf_regs: sclk idle low, data steady while sclk high
`timescale 1ns/1ps
`default_nettype none
module pcf_vco_model (
  input wire logic i_sys_clk,
  input wire pcf_pkg::pcf_link_t i_link,
  output logic [15:0] o_last,
  output int o_frames,
  output int o_bits,
  output int o_stray
);
  import pcf_pkg::*;
  logic sclk_q = 1'b0;
  logic sen_q = 1'b0;
  logic [15:0] shift = 16'h0000;
  int cnt = 0;
  initial begin
    o_last = 16'h0000;
    o_frames = 0;
    o_bits = 0;
    o_stray = 0;
  end
  ////////////////////////////////////////////////////////////////
  always @(posedge i_sys_clk) begin
    if (i_link.sclk && !sclk_q) begin
      if (i_link.sen) begin
        shift <= {shift[14:0], i_link.sdata};
        cnt <= cnt + 1;
      end else begin
        o_stray <= o_stray + 1;
      end
    end
    if (sen_q && !i_link.sen) begin
      o_last <= shift;
      o_bits <= cnt;
      o_frames <= o_frames + 1;
      cnt <= 0;
    end
    sclk_q <= i_link.sclk;
    sen_q <= i_link.sen;
  end
endmodule
`default_nettype wire

// [bench/testbench.sv]
// Self-checking bench for the register bank and its link forwarder
// Assumes one-cycle register requests, driven on the falling edge
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pcf_pkg::*;
  localparam logic [23:0] ID = 24'h3c5a96; // Arbitrary value
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  pcf_reg_req_t req = '0;
  logic open_m = 1'b0;
  logic frac_m = 1'b0;
  logic buf_on = 1'b0;
  logic cal_wr = 1'b0;
  logic [8:0] cal_pl = 9'h000;
  logic [23:0] rdata;
  logic rvalid, srst, busy;
  logic [4:0] rptr;
  logic [13:0] refdiv;
  logic [18:0] intdiv;
  logic [23:0] fracdiv;
  pcf_link_t link;
  logic [15:0] last;
  int frames, bits, stray;
  int errors = 0;
  int check_count = 0;
  int srst_cnt = 0;
  int busy_run = 0;
  int busy_len = 0;
  pcf_regs #(.IDENTITY_CODE(ID)) dut (.i_sys_clk(clk), .i_reset_n(rst_n), .i_req(req),
    .i_open_mode(open_m), .i_frac_mode(frac_m), .i_reference_buffer_on(buf_on),
    .i_cal_wr(cal_wr), .i_cal_payload(cal_pl), .o_rdata(rdata), .o_rvalid(rvalid),
    .o_read_pointer(rptr), .o_soft_reset(srst), .o_ref_divider(refdiv),
    .o_integer_divide(intdiv), .o_frac_divide(fracdiv), .o_link_busy(busy), .o_link(link));
  pcf_vco_model vco (.i_sys_clk(clk), .i_link(link), .o_last(last), .o_frames(frames),
    .o_bits(bits), .o_stray(stray));
  always #12.5 clk = ~clk;
  always @(negedge clk) begin
    if (srst === 1'b1) begin
      srst_cnt++;
    end
  end
  // Frame length measured from busy itself, so a late frame call cannot shorten it
  always @(negedge clk) begin
    if (busy === 1'b1) begin
      busy_run++;
    end else if (busy_run != 0) begin
      busy_len = busy_run;
      busy_run = 0;
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [24:0] g, input logic [24:0] e, input string m);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [23:0] d);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(negedge clk);
    req.wr = 1'b0;
    @(negedge clk);
  endtask
  task automatic rd(input logic [4:0] a, input logic [23:0] e);
    int n;
    req.rd = 1'b1;
    req.addr = a;
    @(negedge clk);
    req.rd = 1'b0;
    n = 0;
    while (rvalid !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    cmp({rvalid, rdata}, {1'b1, e}, "read");
    @(negedge clk);
  endtask
  // Waits out one frame; half period fixed by rate select, so length is exact
  task automatic frame(input logic [15:0] e, input int cyc);
    int n, f;
    f = frames;
    n = 0;
    while (busy !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while (busy === 1'b1 && n < 600) begin
      @(negedge clk);
      n++;
    end
    repeat (2) @(negedge clk);
    cmp(25'(busy_len), 25'(cyc), "frame length");
    cmp(25'(last), 25'(e), "packet");
    cmp(25'(bits), 25'd16, "bits");
    cmp(25'(frames - f), 25'd1, "frames");
  endtask
  task automatic cal(input logic [8:0] p);
    cal_pl = p;
    cal_wr = 1'b1;
    @(negedge clk);
    cal_wr = 1'b0;
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(negedge clk);
    errors++;
    $display("BAD %0t watchdog expired", $time);
    results();
  end
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    cmp(25'(refdiv), 25'd1, "refdiv out");
    cmp(25'(intdiv), 25'h19, "intdiv out");
    rd(5'h00, ID);
    rd(5'h01, 24'h000002);
    rd(5'h02, 24'h000001);
    rd(5'h03, 24'h000019);
    rd(5'h0a, 24'h002000);
    rd(5'h07, 24'h000000);
    $display("test reset values done");
    open_m = 1'b1;
    wr(5'h00, 24'h000013);
    cmp(25'(rptr), 25'h13, "pointer");
    rd(5'h00, ID);
    open_m = 1'b0;
    wr(5'h00, 24'h000004);
    cmp(25'(rptr), 25'h13, "pointer kept");
    $display("test register zero done");
    wr(5'h02, 24'h003fff);
    cmp(25'(refdiv), 25'd1, "refdiv gated");
    buf_on = 1'b1;
    repeat (2) @(negedge clk);
    cmp(25'(refdiv), 25'h3fff, "refdiv on");
    frac_m = 1'b1;
    wr(5'h03, 24'h07fffc);
    wr(5'h04, 24'habcdef);
    cmp(25'(intdiv), 25'h7fffc, "intdiv");
    cmp(25'(fracdiv), 25'habcdef, "frac on");
    frac_m = 1'b0;
    wr(5'h03, 24'h000010);
    cmp(25'(fracdiv), 25'h0, "frac off");
    rd(5'h03, 24'h000010);
    wr(5'h00, 24'h000020);
    cmp(25'(srst_cnt), 25'd1, "soft reset pulse");
    cmp(25'(rptr), 25'h0, "pointer cleared");
    rd(5'h02, 24'h003fff);
    $display("test dividers done");
    wr(5'h05, 24'h001f10);
    frame(16'h1f10, 64);
    rd(5'h05, 24'h001f10);
    wr(5'h05, 24'h000080);
    wr(5'h05, 24'h000100);
    frame(16'h0080, 64);
    frame(16'h0100, 64);
    cal(9'h155);
    frame(16'haa80, 64);
    rd(5'h05, 24'h00aa80);
    wr(5'h05, 24'h000038);
    frame(16'h0038, 64);
    cal(9'h001);
    frame(16'h00b8, 64);
    wr(5'h05, 24'h00b500);
    frame(16'hb500, 64);
    wr(5'h0a, 24'h000000);
    rd(5'h0a, 24'h000000);
    wr(5'h05, 24'h001f10);
    frame(16'h1f10, 32);
    cmp(25'(stray), 25'd0, "clock outside frame");
    $display("test link done");
    results();
  end
endmodule
`default_nettype wire
